//--- spm_speed_input.sv
`timescale 1ns/1ps
module spm_speed_input #(
    parameter int SAMPLE_CYC_P   = spm_pkg::SAMPLE_CYC,
    parameter int MPU_TIMEOUT_P  = spm_pkg::MPU_TIMEOUT_CYC,
    parameter int PROX_TIMEOUT_P = int'(spm_pkg::PROX_TIMEOUT_CYC)
) (
    input  wire logic                                        clock,
    input  wire logic                                        rst,
    input  wire logic [spm_pkg::NUM_CH-1:0]                  pulse_in,
    input  wire spm_pkg::spm_chan_cfg_type [spm_pkg::NUM_CH-1:0] chan_cfg,
    input  wire spm_pkg::spm_group_wr_type                   group_wr,
    input  wire spm_pkg::spm_key_type                        key,
    input  wire logic                                        init_done,
    input  wire logic                                        diag_fail,
    input  wire logic [spm_pkg::RAM_AW-1:0]                  rd_addr,
    output logic      [spm_pkg::SPD_W-1:0]                   rd_data,
    output logic                                             fault_led
);
    import spm_pkg::*;

    // =========================================================
    // Input synchronisers and edge detect
    // =========================================================
    logic [NUM_CH-1:0] sync1;
    logic [NUM_CH-1:0] sync2;
    logic [NUM_CH-1:0] sync_prev;
    logic [NUM_CH-1:0] in_edge;

    always_ff @(posedge clock) begin
        if (rst) begin
            sync1     <= '0;
            sync2     <= '0;
            sync_prev <= '0;
        end else begin
            sync1     <= pulse_in;
            sync2     <= sync1;
            sync_prev <= sync2;
        end
    end

    assign in_edge = sync2 & ~sync_prev;

    // =========================================================
    // Per-channel prescaler and period counter
    // =========================================================
    logic [PSC_CNT_W-1:0] psc_cnt   [NUM_CH];
    logic [PER_W-1:0]     per_cnt   [NUM_CH];
    logic [PER_W-1:0]     period    [NUM_CH];
    logic [PER_W-1:0]     limit     [NUM_CH];
    logic                 per_valid [NUM_CH];
    logic                 timed_out [NUM_CH];
    logic                 psc_hit   [NUM_CH];

    for (genvar i = 0; i < NUM_CH; i++) begin : g_chan
        logic [PSC_CNT_W-1:0] psc_top;
        logic [PSC_CNT_W-1:0] next_psc_cnt;
        logic [PER_W-1:0]     next_per_cnt;
        logic [PER_W-1:0]     next_period;
        logic                 next_per_valid;
        logic                 next_timed_out;

        assign psc_top    = PSC_CNT_W'((5'h01 << chan_cfg[i].prescale) - 5'h01);
        assign psc_hit[i] = in_edge[i] && (psc_cnt[i] == psc_top);
        // Longest period scales with prescale; channel type fixed by strap
        assign limit[i] = PER_W'((chan_cfg[i].magnetic_pickup ? longint'(MPU_TIMEOUT_P)
                                                   : longint'(PROX_TIMEOUT_P)) << chan_cfg[i].prescale);

        always_comb begin
            next_psc_cnt   = psc_cnt[i];
            next_per_cnt   = per_cnt[i];
            next_period    = period[i];
            next_per_valid = per_valid[i];
            next_timed_out = timed_out[i];
            if (in_edge[i]) begin
                next_psc_cnt = psc_hit[i] ? '0 : psc_cnt[i] + 1'b1;
            end
            if (psc_hit[i]) begin
                next_period    = per_cnt[i] + 1'b1;
                next_per_cnt   = '0;
                next_per_valid = 1'b1;
                next_timed_out = 1'b0;
            end else if (per_cnt[i] >= limit[i]) begin
                next_timed_out = 1'b1;
            end else begin
                next_per_cnt = per_cnt[i] + 1'b1;
            end
        end

        always_ff @(posedge clock) begin
            if (rst) begin
                psc_cnt[i]   <= '0;
                per_cnt[i]   <= '0;
                period[i]    <= '0;
                per_valid[i] <= 1'b0;
                timed_out[i] <= 1'b0;
            end else begin
                psc_cnt[i]   <= next_psc_cnt;
                per_cnt[i]   <= next_per_cnt;
                period[i]    <= next_period;
                per_valid[i] <= next_per_valid;
                timed_out[i] <= next_timed_out;
            end
        end
    end

    // =========================================================
    // Sample tick
    // =========================================================
    logic [PER_W-1:0] sample_cnt;
    logic [PER_W-1:0] next_sample_cnt;
    logic             tick;
    logic             next_tick;

    always_comb begin
        next_tick       = 1'b0;
        next_sample_cnt = sample_cnt + 1'b1;
        if (sample_cnt == PER_W'(SAMPLE_CYC_P - 1)) begin
            next_sample_cnt = '0;
            next_tick       = 1'b1;
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            sample_cnt <= '0;
            tick       <= 1'b0;
        end else begin
            sample_cnt <= next_sample_cnt;
            tick       <= next_tick;
        end
    end

    // =========================================================
    // Shared divider, self-test and filters
    // =========================================================
    // One serial divider serves all channels; 4 x 33 cycles fits the 100 us slot easily
    spm_state_type          state;
    spm_state_type          next_state;
    logic [PER_W-1:0]       rem;
    logic [PER_W-1:0]       quo;
    logic [PER_W-1:0]       den;
    logic [DIV_CNT_W-1:0]   bits;
    logic [CH_W-1:0]        ch;
    logic                   test_ok;
    logic [PER_W-1:0]       next_rem;
    logic [PER_W-1:0]       next_quo;
    logic [PER_W-1:0]       next_den;
    logic [DIV_CNT_W-1:0]   next_bits;
    logic [CH_W-1:0]        next_ch;
    logic                   next_test_ok;
    logic [PER_W:0]         shifted;
    logic [PER_W:0]         trial;
    logic [PER_W-1:0]       step_rem;
    logic [PER_W-1:0]       step_quo;
    logic [FILT_W-1:0]      y1 [NUM_CH];
    logic [FILT_W-1:0]      y2 [NUM_CH];
    logic signed [FILT_W:0] dd [NUM_CH];
    logic [FILT_W-1:0]      next_y1 [NUM_CH];
    logic [FILT_W-1:0]      next_y2 [NUM_CH];
    logic signed [FILT_W:0] next_dd [NUM_CH];
    logic [SPD_W-1:0]       spd_x;
    logic signed [FILT_W:0] e1;
    logic signed [FILT_W:0] e2;
    logic signed [FILT_W:0] dv;
    logic signed [FILT_W:0] e3;
    logic [FILT_W-1:0]      y1n;
    logic [FILT_W-1:0]      y2n;
    logic [CH_W-1:0]        nc;

    assign shifted  = {rem, quo[PER_W-1]};
    assign trial    = shifted - {1'b0, den};
    assign step_rem = trial[PER_W] ? shifted[PER_W-1:0] : trial[PER_W-1:0];
    assign step_quo = {quo[PER_W-2:0], ~trial[PER_W]};

    // Speed saturates at full range; timed-out or unmeasured channel reads zero
    always_comb begin
        spd_x = '0;
        if (per_valid[ch] && !timed_out[ch]) begin
            spd_x = (quo[PER_W-1:SPD_W] != '0) ? SPD_MAX : quo[SPD_W-1:0];
        end
    end

    always_comb begin
        next_state   = state;
        next_rem     = rem;
        next_quo     = quo;
        next_den     = den;
        next_bits    = bits;
        next_ch      = ch;
        next_test_ok = test_ok;
        next_y1      = y1;
        next_y2      = y2;
        next_dd      = dd;
        nc           = ch + 1'b1;
        e1  = $signed({1'b0, spd_x, {FRAC_W{1'b0}}}) - $signed({1'b0, y1[ch]});
        y1n = y1[ch] + FILT_W'(e1 >>> chan_cfg[ch].filt_shift);
        e2  = $signed({1'b0, y1n}) - $signed({1'b0, y2[ch]});
        y2n = y2[ch] + FILT_W'(e2 >>> chan_cfg[ch].filt_shift);
        dv  = $signed({1'b0, y2n}) - $signed({1'b0, y2[ch]});
        e3  = dv - dd[ch];
        case (state)
            ST_SELF: begin
                next_rem  = step_rem;
                next_quo  = step_quo;
                next_bits = bits + 1'b1;
                if (bits == DIV_LAST) begin
                    next_test_ok = (step_quo == TEST_QUO);
                    next_state   = ST_IDLE;
                end
            end
            ST_IDLE: begin
                if (tick) begin
                    next_ch    = '0;
                    next_rem   = '0;
                    next_quo   = chan_cfg[0].range_num;
                    next_den   = period[0];
                    next_bits  = '0;
                    next_state = ST_DIV;
                end
            end
            ST_DIV: begin
                next_rem  = step_rem;
                next_quo  = step_quo;
                next_bits = bits + 1'b1;
                if (bits == DIV_LAST) begin
                    next_state = ST_FILT;
                end
            end
            ST_FILT: begin
                next_y1[ch] = y1n;
                next_y2[ch] = y2n;
                next_dd[ch] = dd[ch] + (e3 >>> chan_cfg[ch].deriv_shift);
                if (ch == CH_W'(NUM_CH - 1)) begin
                    next_state = ST_IDLE;
                end else begin
                    next_ch    = nc;
                    next_rem   = '0;
                    next_quo   = chan_cfg[nc].range_num;
                    next_den   = period[nc];
                    next_bits  = '0;
                    next_state = ST_DIV;
                end
            end
            default: begin
                next_state = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            state   <= ST_SELF;
            rem     <= '0;
            quo     <= TEST_NUM;
            den     <= TEST_DEN;
            bits    <= '0;
            ch      <= '0;
            test_ok <= 1'b0;
            y1      <= '{default: '0};
            y2      <= '{default: '0};
            dd      <= '{default: '0};
        end else begin
            state   <= next_state;
            rem     <= next_rem;
            quo     <= next_quo;
            den     <= next_den;
            bits    <= next_bits;
            ch      <= next_ch;
            test_ok <= next_test_ok;
            y1      <= next_y1;
            y2      <= next_y2;
            dd      <= next_dd;
        end
    end

    // =========================================================
    // Rate groups, shared RAM, fault indicator
    // =========================================================
    // Word 2n holds channel n speed, word 2n+1 its derivative
    logic [GRP_W-1:0] grp      [NUM_CH];
    logic [GRP_W-1:0] next_grp [NUM_CH];
    logic [SPD_W-1:0] mem      [RAM_WORDS];
    logic [SPD_W-1:0] next_mem [RAM_WORDS];
    logic             init_seen;
    logic             next_init_seen;
    logic             next_fault;

    always_comb begin
        next_grp = grp;
        next_mem = mem;
        for (int i = 0; i < NUM_CH; i++) begin
            if (group_wr.valid) begin
                next_grp[i] = group_wr.groups[i*GRP_W +: GRP_W];
            end
            if (key.valid && key.due[grp[i]]) begin
                next_mem[2*i]   = y2[i][FILT_W-1:FRAC_W];
                next_mem[2*i+1] = SPD_W'(dd[i]);
            end
        end
    end

    always_comb begin
        next_init_seen = init_seen | init_done;
        next_fault     = fault_led;
        if (test_ok && init_seen && !diag_fail) begin
            next_fault = 1'b0;
        end
        if (diag_fail) begin
            next_fault = 1'b1;
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            grp       <= '{default: '0};
            mem       <= '{default: '0};
            rd_data   <= '0;
            init_seen <= 1'b0;
            fault_led <= 1'b1;
        end else begin
            grp       <= next_grp;
            mem       <= next_mem;
            rd_data   <= mem[rd_addr];
            init_seen <= next_init_seen;
            fault_led <= next_fault;
        end
    end

    // =========================================================
    // Assertions
    // =========================================================
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);

    sequence s_sample_start;
        state == ST_IDLE && tick;
    endsequence

    sequence s_div_run;
        state == ST_DIV [*8];
    endsequence

    chk_fault_reset: assert property ($past(rst) |-> fault_led)
        else $error("fault indicator not on after reset");
    chk_fault_diag: assert property (diag_fail |=> fault_led)
        else $error("fault indicator off while diagnostics fail");
    chk_fault_off: assert property ($fell(fault_led) |-> $past(test_ok && init_seen))
        else $error("fault indicator cleared too early");
    chk_sample_tick: assert property (tick |-> $past(sample_cnt) == PER_W'(SAMPLE_CYC_P - 1))
        else $error("sample tick at wrong spacing");
    chk_div_span: assert property (s_sample_start |=> s_div_run)
        else $error("division did not run after tick");
    chk_period_latch: assert property (psc_hit[0] |=> period[0] == PER_W'($past(per_cnt[0]) + 1))
        else $error("period not latched on prescaled edge");
    chk_timeout_set: assert property (per_cnt[0] >= limit[0] && !psc_hit[0] |=> timed_out[0])
        else $error("timeout flag not set");
    chk_timeout_zero: assert property (state == ST_FILT && timed_out[ch] |-> spd_x == '0)
        else $error("timed out channel gives nonzero speed");
    chk_group_store: assert property (group_wr.valid |=> grp[0] == $past(group_wr.groups[GRP_W-1:0]))
        else $error("rate group not stored");
    chk_key_copy: assert property (key.valid && key.due[grp[0]]
                                   |=> mem[0] == $past(y2[0][FILT_W-1:FRAC_W]))
        else $error("due channel not copied");
    chk_key_hold: assert property (!(key.valid && key.due[grp[0]]) |=> $stable(mem[0]))
        else $error("channel copied while not due");
endmodule : spm_speed_input

//--- spm_pkg.sv
package spm_pkg;
    // =========================================================
    // Sizes
    // =========================================================
    localparam int NUM_CH    = 4;
    localparam int CH_W      = 2;
    localparam int PER_W     = 32;
    localparam int SPD_W     = 16;
    localparam int FRAC_W    = 8;
    localparam int FILT_W    = SPD_W + FRAC_W;
    localparam int PSC_W     = 2;
    localparam int PSC_CNT_W = 4;
    localparam int SHIFT_W   = 5;
    localparam int GRP_W     = 2;
    localparam int NUM_GRP   = 4;
    localparam int DIV_CNT_W = 5;
    localparam int RAM_AW    = 3;
    localparam int RAM_WORDS = 2 * NUM_CH;
    // =========================================================
    // Timing
    // =========================================================
    localparam int     CLK_HZ           = 250_000_000;
    localparam int     SAMPLE_US        = 100;
    localparam int     SAMPLE_CYC       = CLK_HZ / 1_000_000 * SAMPLE_US;
    localparam int     MPU_MIN_HZ       = 50;
    localparam int     PROX_MIN_MILLIHZ = 500;
    localparam int     MPU_TIMEOUT_CYC  = CLK_HZ / MPU_MIN_HZ;
    localparam longint PROX_TIMEOUT_CYC = longint'(CLK_HZ) * 1000 / PROX_MIN_MILLIHZ;
    // =========================================================
    // Values
    // =========================================================
    localparam logic [SPD_W-1:0]     SPD_MAX  = 16'hFFFF;
    localparam logic [DIV_CNT_W-1:0] DIV_LAST = 5'h1F;
    localparam logic [PER_W-1:0]     TEST_NUM = 32'h0001_2345;
    localparam logic [PER_W-1:0]     TEST_DEN = 32'h0000_0010;
    localparam logic [PER_W-1:0]     TEST_QUO = 32'h0000_1234;

    typedef struct packed {
        logic                 magnetic_pickup;
        logic [PSC_W-1:0]     prescale;
        logic [PER_W-1:0]     range_num;
        logic [SHIFT_W-1:0]   filt_shift;
        logic [SHIFT_W-1:0]   deriv_shift;
    } spm_chan_cfg_type;

    typedef struct packed {
        logic                      valid;
        logic [GRP_W*NUM_CH-1:0]   groups;
    } spm_group_wr_type;

    typedef struct packed {
        logic                 valid;
        logic [NUM_GRP-1:0]   due;
    } spm_key_type;

    typedef enum logic [1:0] {ST_SELF, ST_IDLE, ST_DIV, ST_FILT} spm_state_type;
endpackage : spm_pkg

//--- spm_cpu_model.sv
`timescale 1ns/1ps
module spm_cpu_model (
    input  wire logic                      clock,
    input  wire logic [spm_pkg::SPD_W-1:0] rd_data,
    output spm_pkg::spm_group_wr_type      group_wr,
    output spm_pkg::spm_key_type           key,
    output logic                           init_done,
    output logic                           diag_fail,
    output logic [spm_pkg::RAM_AW-1:0]     rd_addr
);
    import spm_pkg::*;

    initial begin
        group_wr  = '0;
        key       = '0;
        init_done = 1'b0;
        diag_fail = 1'b0;
        rd_addr   = '0;
    end

    // =========================================================
    // Initialization and run-time requests
    // =========================================================
    task automatic assign_groups(input logic [GRP_W*NUM_CH-1:0] groups);
        @(posedge clock);
        #1;
        group_wr = '{valid: 1'b1, groups: groups};
        @(posedge clock);
        #1;
        group_wr.valid = 1'b0;
    endtask : assign_groups

    task automatic send_key(input logic [NUM_GRP-1:0] due);
        @(posedge clock);
        #1;
        key = '{valid: 1'b1, due: due};
        @(posedge clock);
        #1;
        key.valid = 1'b0;
    endtask : send_key

    // Init stays high once given: the module latches it anyway
    task automatic set_init(input logic v);
        @(posedge clock);
        #1;
        init_done = v;
    endtask : set_init

    task automatic set_diag(input logic v);
        @(posedge clock);
        #1;
        diag_fail = v;
    endtask : set_diag

    // =========================================================
    // Shared RAM read, data one edge after the address
    // =========================================================
    task automatic read_word(input logic [RAM_AW-1:0] addr, output logic [SPD_W-1:0] data);
        @(posedge clock);
        #1;
        rd_addr = addr;
        @(posedge clock);
        #1;
        data = rd_data;
    endtask : read_word
endmodule : spm_cpu_model

//--- tb_speed_input_period_measure.sv
`timescale 1ns/1ps
module tb_speed_input_period_measure;
    import spm_pkg::*;

    // Measured period per channel after prescale, in clock cycles
    localparam int               PER_CYC [NUM_CH] = '{20, 40, 40, 80};
    localparam logic [SPD_W-1:0] SPD_EXP [NUM_CH] = '{16'h1234, 16'h0ABC, 16'h7FFF, 16'hFFFF};

    logic                                clock;
    logic                                rst;
    logic [NUM_CH-1:0]                   pulse_in;
    spm_chan_cfg_type [NUM_CH-1:0]       chan_cfg;
    spm_group_wr_type                    group_wr;
    spm_key_type                         key;
    logic                                init_done;
    logic                                diag_fail;
    logic [RAM_AW-1:0]                   rd_addr;
    logic [SPD_W-1:0]                    rd_data;
    logic                                fault_led;
    logic [NUM_CH-1:0]                   run_en;
    int                                  cnt [NUM_CH];
    logic [SPD_W-1:0]                    exp_mem [RAM_WORDS];
    int                                  err_total;
    int                                  tests_run;

    spm_speed_input #(
        .SAMPLE_CYC_P   (200),
        .MPU_TIMEOUT_P  (500),
        .PROX_TIMEOUT_P (2000)
    ) DUT (
        .clock     (clock),
        .rst       (rst),
        .pulse_in  (pulse_in),
        .chan_cfg  (chan_cfg),
        .group_wr  (group_wr),
        .key       (key),
        .init_done (init_done),
        .diag_fail (diag_fail),
        .rd_addr   (rd_addr),
        .rd_data   (rd_data),
        .fault_led (fault_led)
    );

    spm_cpu_model cpu (
        .clock     (clock),
        .rd_data   (rd_data),
        .group_wr  (group_wr),
        .key       (key),
        .init_done (init_done),
        .diag_fail (diag_fail),
        .rd_addr   (rd_addr)
    );

    initial begin
        clock = 1'b0;
        forever #2 clock = ~clock;
    end

    // =========================================================
    // Sensor pulse trains, raw period = measured period >> prescale
    // =========================================================
    always @(posedge clock) begin
        #1;
        for (int n = 0; n < NUM_CH; n++) begin
            if (run_en[n]) begin
                cnt[n] = (cnt[n] + 1) % (PER_CYC[n] >> n);
                pulse_in[n] = (cnt[n] < (PER_CYC[n] >> (n + 1)));
            end else begin
                pulse_in[n] = 1'b0;
            end
        end
    end

    // =========================================================
    // Compare and report
    // =========================================================
    task automatic check_word(input string what, input logic [SPD_W-1:0] exp, input logic [SPD_W-1:0] got);
        tests_run++;
        if (got !== exp) begin
            err_total++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask : check_word

    task automatic check_bit(input string what, input logic exp, input logic got);
        tests_run++;
        if (got !== exp) begin
            err_total++;
            $display("wrong value %s expected %b seen %b", what, exp, got);
        end
    endtask : check_bit

    task automatic summarize();
        $display("checks %0d mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : summarize

    task automatic check_ram();
        logic [SPD_W-1:0] got;
        for (int a = 0; a < RAM_WORDS; a++) begin
            cpu.read_word(RAM_AW'(a), got);
            check_word($sformatf("ram word %0d", a), exp_mem[a], got);
        end
    endtask : check_ram

    // Bounded: a stuck indicator ends the run as a mismatch
    task automatic wait_led_off();
        int i;
        i = 0;
        while (fault_led !== 1'b0 && i < 20) begin
            @(posedge clock);
            #1;
            i++;
        end
        check_bit("fault_led off", 1'b0, fault_led);
        if (i == 20) summarize();
    endtask : wait_led_off

    // =========================================================
    // Main sequence
    // =========================================================
    initial begin
        err_total = 0;
        tests_run = 0;
        rst       = 1'b1;
        run_en    = '0;
        pulse_in  = '0;
        exp_mem   = '{default: '0};
        for (int n = 0; n < NUM_CH; n++) begin
            cnt[n] = 0;
            chan_cfg[n].magnetic_pickup         = (n != 2);
            chan_cfg[n].prescale    = PSC_W'(n);
            chan_cfg[n].range_num   = PER_W'(PER_CYC[n]) * PER_W'(SPD_EXP[n]);
            chan_cfg[n].filt_shift  = '0;
            chan_cfg[n].deriv_shift = '0;
        end
        // Quotient far above full scale, must clip
        chan_cfg[3].range_num = 32'h0100_0000;
        repeat (3) @(posedge clock);
        #1;
        rst = 1'b0;
        check_bit("fault_led after reset", 1'b1, fault_led);
        check_ram();
        repeat (40) @(posedge clock);
        #1;
        check_bit("fault_led before init", 1'b1, fault_led);
        cpu.set_init(1'b1);
        wait_led_off();
        cpu.set_diag(1'b1);
        @(posedge clock);
        #1;
        check_bit("fault_led diag fail", 1'b1, fault_led);
        cpu.set_diag(1'b0);
        wait_led_off();
        cpu.assign_groups(8'hE4);
        run_en = 4'hF;
        repeat (1500) @(posedge clock);
        cpu.send_key(4'h1);
        exp_mem[0] = SPD_EXP[0];
        check_ram();
        cpu.send_key(4'hE);
        for (int n = 0; n < NUM_CH; n++) exp_mem[2*n] = SPD_EXP[n];
        check_ram();
        // Stop three sensors; the proximity one has the longest limit
        run_en = 4'h8;
        repeat (9000) @(posedge clock);
        cpu.assign_groups(8'hE0);
        cpu.send_key(4'h1);
        exp_mem[0] = '0;
        exp_mem[2] = '0;
        check_ram();
        cpu.send_key(4'h4);
        exp_mem[4] = '0;
        check_ram();
        // Mid-run reset, then slow poles on channel 0 so the filter shifts are exercised
        run_en = 4'h9;
        chan_cfg[0].filt_shift  = SHIFT_W'(1);
        chan_cfg[0].deriv_shift = SHIFT_W'(1);
        rst = 1'b1;
        repeat (3) @(posedge clock);
        #1;
        rst = 1'b0;
        check_bit("fault_led after second reset", 1'b1, fault_led);
        repeat (40) @(posedge clock);
        #1;
        wait_led_off();
        // Long enough for both poles and the derivative pole to settle
        repeat (40000) @(posedge clock);
        cpu.send_key(4'h1);
        exp_mem = '{default: '0};
        // Floor rounding leaves each speed pole one fraction LSB short of the input
        exp_mem[0] = SPD_EXP[0] - 16'h0001;
        exp_mem[6] = SPD_EXP[3];
        check_ram();
        summarize();
    end
endmodule : tb_speed_input_period_measure
